// [design/serial_control_enables.sv]
// Control, status and interrupt logic of a serial interface.
// Assumes framing and shift logic outside, which takes transmit bytes,
// reports transmit end and hands over received frames as pulses.
`timescale 1ns/1ns
`default_nettype none
`include "serial_ctrl_regs.svh"

// Functional notes
// [R1] Prescale field 00/01/10/11 feeds generator phi, phi/4, phi/16, phi/64.
// [R2] Transmit-empty request only while transmit interrupt enable is one.
// [R3] Receive interrupt enable gates both receive-full and receive-error requests.
// [R4] Transmission happens only while the transmit enable bit is one.
// [R5] Reception happens only while the receive enable bit is one.
// [R6] Wake enable acts only in asynchronous mode with multiprocessor format.
// [R7] While waking, frames with multiprocessor bit zero are dropped silently.
// [R8] Frame with multiprocessor bit one clears wake enable, normal reception.
// [R9] Transmit-end request only while transmit end interrupt enable is one.
// [R10] Software never sets status flags; writing zero clears them.
// [R11] Software keeps wake and transmit-end enables zero in smart card mode.
// [R12] Each request is flag AND enable; enables reset to zero.
module serial_control_enables (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        tx_take,
    input  wire logic        tx_end_pulse,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_mpb,
    input  wire logic        rx_parity_bad,
    input  wire logic        rx_stop_bad,
    output logic             baud_tick,
    output logic      [1:0]  prescale_n,
    output logic             tx_on,
    output logic             rx_on,
    output logic             tx_valid,
    output logic      [7:0]  tx_byte,
    output logic             tx_empty_irq,
    output logic             rx_full_irq,
    output logic             rx_error_irq,
    output logic             tx_done_irq,
    output logic             irq
);

    serial_ctrl_pkg::byte_t mode_reg;
    serial_ctrl_pkg::byte_t control_reg;
    serial_ctrl_pkg::byte_t tx_data_reg;
    serial_ctrl_pkg::byte_t rx_data_reg;
    logic                   tx_empty_flag;
    logic                   rx_full_flag;
    logic                   overrun_flag;
    logic                   framing_err_flag;
    logic                   parity_err_flag;
    logic                   tx_end_flag;
    logic                   mpb_seen_reg;
    logic [3:0]             irq_status_reg;
    logic [3:0]             irq_mask_reg;
    logic [3:0]             irq_event;
    logic                   tx_empty_irq_en;
    logic                   rx_irq_en;
    logic                   mp_wake_en;
    logic                   tx_done_irq_en;
    logic                   multiproc_format;
    logic                   async_mode;
    logic                   wake_active;
    logic                   rx_accept;
    logic                   rx_skip;
    logic                   rx_land;
    logic                   rx_overrun;
    logic                   tx_fire;
    logic                   wr_mode;
    logic                   wr_ctl;
    logic                   wr_status;
    logic                   wr_txd;
    logic                   wr_irq_st;
    logic                   wr_irq_mask;
    logic                   txe_clear;
    logic                   rxf_clear;
    logic                   ovr_clear;
    logic                   fer_clear;
    logic                   per_clear;

    // Write decode for one register offset
    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] ofs,
                                 input logic       strobe);
        hit = strobe && (addr == ofs);
    endfunction : hit

    // A flag clears only when written as zero
    function automatic logic zero_clear(input logic sel,
                                        input logic wbit);
        zero_clear = sel && !wbit;
    endfunction : zero_clear

    // Register decode
    assign wr_mode     = hit(reg_addr, `OFS_MODE, reg_wr);
    assign wr_ctl      = hit(reg_addr, `OFS_CONTROL, reg_wr);
    assign wr_status   = hit(reg_addr, `OFS_STATUS, reg_wr);
    assign wr_txd      = hit(reg_addr, `OFS_TX_DATA, reg_wr);
    assign wr_irq_st   = hit(reg_addr, `OFS_IRQ_STATUS, reg_wr);
    assign wr_irq_mask = hit(reg_addr, `OFS_IRQ_MASK, reg_wr);

    // Control fields
    assign tx_empty_irq_en  = control_reg[`CTL_TIE_BIT];
    assign rx_irq_en        = control_reg[`CTL_RIE_BIT];
    assign tx_on            = control_reg[`CTL_TXON_BIT];
    assign rx_on            = control_reg[`CTL_RXON_BIT];
    assign mp_wake_en       = control_reg[`CTL_MPW_BIT];
    assign tx_done_irq_en   = control_reg[`CTL_TX_DONE_IRQ_EN_BIT];
    assign multiproc_format = mode_reg[`MODE_MPF_BIT];
    assign async_mode       = !mode_reg[`MODE_SYNC_BIT];

    // Prescale select drives n directly
    assign prescale_n = {mode_reg[`MODE_PRE_HI_BIT],
                         mode_reg[`MODE_PRE_LO_BIT]};       // [R1]

    // Prescaler runs only while a direction is on
    baud_prescaler #(
        .CNT_W (6)
    ) u_prescaler (
        .clk  (clk),
        .rst  (rst),
        .run  (tx_on || rx_on),
        .sel  (serial_ctrl_pkg::prescale_e'(prescale_n)),  // [R1]
        .tick (baud_tick)
    );

    // Mode register
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= `MODE_RESET;
        end else if (wr_mode) begin
            mode_reg <= reg_wdata;
        end
    end

    // Wake filter is live only in async multiprocessor format
    assign wake_active = mp_wake_en && async_mode
                         && multiproc_format;                // [R6]

    // Receive qualification
    assign rx_accept  = rx_valid && rx_on;                   // [R5]
    assign rx_skip    = rx_accept && wake_active && !rx_mpb; // [R7]
    assign rx_land    = rx_accept && !rx_skip;
    assign rx_overrun = rx_land && rx_full_flag && !rxf_clear;

    // Control register; hardware clears wake enable on a wake frame
    always_ff @(posedge clk) begin
        if (rst) begin
            control_reg <= `CONTROL_RESET;                   // [R12]
        end else begin
            if (wr_ctl) begin
                control_reg <= reg_wdata;
            end
            if (rx_accept && wake_active && rx_mpb) begin
                control_reg[`CTL_MPW_BIT] <= 1'b0;           // [R8]
            end
        end
    end

    // Zero-write clears of status flags
    assign txe_clear = zero_clear(wr_status, reg_wdata[`ST_TXE_BIT]);
    assign rxf_clear = zero_clear(wr_status, reg_wdata[`ST_RXF_BIT]);
    assign ovr_clear = zero_clear(wr_status, reg_wdata[`ST_OVR_BIT]);
    assign fer_clear = zero_clear(wr_status, reg_wdata[`ST_FER_BIT]);
    assign per_clear = zero_clear(wr_status, reg_wdata[`ST_PER_BIT]);

    // Transmit byte goes out only while transmit is on
    assign tx_valid = tx_on && !tx_empty_flag;               // [R4]
    assign tx_fire  = tx_take && tx_valid;                   // [R4]
    assign tx_byte  = tx_data_reg;

    // Transmit data holding register
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_data_reg <= 8'h00;
        end else if (wr_txd) begin
            tx_data_reg <= reg_wdata;
        end
    end

    // Transmit empty: set by a take, cleared by a zero write
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_empty_flag <= 1'b1;
        end else if (tx_fire) begin
            tx_empty_flag <= 1'b1;                           // [R10]
        end else if (txe_clear) begin
            tx_empty_flag <= 1'b0;                           // [R10]
        end
    end

    // Transmit end: set by the shifter, cleared with transmit empty
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_end_flag <= 1'b1;
        end else if (tx_end_pulse && tx_on) begin
            tx_end_flag <= 1'b1;
        end else if (txe_clear) begin
            tx_end_flag <= 1'b0;
        end
    end

    // Receive data and multiprocessor bit captured on a landing frame that does not overrun
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_data_reg  <= 8'h00;
            mpb_seen_reg <= 1'b0;
        end else if (rx_land && !rx_overrun) begin
            rx_data_reg  <= rx_byte;
            mpb_seen_reg <= rx_mpb;
        end
    end

    // Receive full; skipped frames never set it
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_full_flag <= 1'b0;
        end else if (rx_land) begin
            rx_full_flag <= 1'b1;                            // [R7]
        end else if (rxf_clear) begin
            rx_full_flag <= 1'b0;                            // [R10]
        end
    end

    // Overrun when a frame lands on unread data
    always_ff @(posedge clk) begin
        if (rst) begin
            overrun_flag <= 1'b0;
        end else if (rx_overrun) begin
            overrun_flag <= 1'b1;                            // [R7]
        end else if (ovr_clear) begin
            overrun_flag <= 1'b0;                            // [R10]
        end
    end

    // Framing error of a landing frame
    always_ff @(posedge clk) begin
        if (rst) begin
            framing_err_flag <= 1'b0;
        end else if (rx_land && rx_stop_bad) begin
            framing_err_flag <= 1'b1;                        // [R7]
        end else if (fer_clear) begin
            framing_err_flag <= 1'b0;                        // [R10]
        end
    end

    // Parity error of a landing frame
    always_ff @(posedge clk) begin
        if (rst) begin
            parity_err_flag <= 1'b0;
        end else if (rx_land && rx_parity_bad) begin
            parity_err_flag <= 1'b1;
        end else if (per_clear) begin
            parity_err_flag <= 1'b0;                         // [R10]
        end
    end

    // Gated interrupt requests to the interrupt controller
    assign tx_empty_irq = tx_empty_flag && tx_empty_irq_en;  // [R2] [R12]
    assign rx_full_irq  = rx_full_flag && rx_irq_en;         // [R3] [R12]
    assign rx_error_irq = (overrun_flag || framing_err_flag
                           || parity_err_flag) && rx_irq_en; // [R3] [R12]
    assign tx_done_irq  = tx_end_flag && tx_done_irq_en;     // [R9] [R12]

    // Rising edges of the gated requests become sticky events
    logic [3:0] req_now;
    logic [3:0] req_prev_reg;

    assign req_now[`IRQ_TXE_BIT]  = tx_empty_irq;
    assign req_now[`IRQ_TEND_BIT] = tx_done_irq;
    assign req_now[`IRQ_RXF_BIT]  = rx_full_irq;
    assign req_now[`IRQ_ERR_BIT]  = rx_error_irq;
    assign irq_event              = req_now & ~req_prev_reg;

    // Previous request levels
    always_ff @(posedge clk) begin
        if (rst) begin
            req_prev_reg <= 4'h0;
        end else begin
            req_prev_reg <= req_now;
        end
    end

    // Sticky status, write one to clear, new event wins
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_status_reg <= 4'h0;
        end else if (wr_irq_st) begin
            irq_status_reg <= (irq_status_reg & ~reg_wdata[3:0])
                              | irq_event;
        end else begin
            irq_status_reg <= irq_status_reg | irq_event;
        end
    end

    // Interrupt mask
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_mask_reg <= `IRQ_MASK_RESET;
        end else if (wr_irq_mask) begin
            irq_mask_reg <= reg_wdata[3:0];
        end
    end

    // One level interrupt line
    assign irq = |(irq_status_reg & irq_mask_reg);

    // Read data one cycle after the read strobe; unmapped reads zero.
    // Idle cycles return zero so a stale read never lingers on the bus.
    // Status bit 0 always reads zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `OFS_MODE:       reg_rdata <= mode_reg;
                `OFS_CONTROL:    reg_rdata <= control_reg;
                `OFS_STATUS:     reg_rdata <= {tx_empty_flag,
                                               rx_full_flag,
                                               overrun_flag,
                                               framing_err_flag,
                                               parity_err_flag,
                                               tx_end_flag,
                                               mpb_seen_reg,
                                               1'b0};
                `OFS_TX_DATA:    reg_rdata <= tx_data_reg;
                `OFS_RX_DATA:    reg_rdata <= rx_data_reg;
                `OFS_IRQ_STATUS: reg_rdata <= {4'h0, irq_status_reg};
                `OFS_IRQ_MASK:   reg_rdata <= {4'h0, irq_mask_reg};
                default:         reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : serial_control_enables
`default_nettype wire

// [design/serial_ctrl_regs.svh]
// Register offsets, field positions, reset values and prescale counts
// for the serial control block.
// Assumes an 8-bit register port with byte-wide data.
`ifndef SERIAL_CTRL_REGS_SVH
`define SERIAL_CTRL_REGS_SVH

// Register offsets on the plain register port
`define OFS_MODE          8'h00
`define OFS_CONTROL       8'h01
`define OFS_STATUS        8'h02
`define OFS_TX_DATA       8'h03
`define OFS_RX_DATA       8'h04
`define OFS_IRQ_STATUS    8'h05
`define OFS_IRQ_MASK      8'h06

// Mode register fields
`define MODE_SYNC_BIT     7
`define MODE_MPF_BIT      2
`define MODE_PRE_HI_BIT   1
`define MODE_PRE_LO_BIT   0

// Control register fields
`define CTL_TIE_BIT       7
`define CTL_RIE_BIT       6
`define CTL_TXON_BIT      5
`define CTL_RXON_BIT      4
`define CTL_MPW_BIT       3
`define CTL_TX_DONE_IRQ_EN_BIT      2

// Status register fields
`define ST_TXE_BIT        7
`define ST_RXF_BIT        6
`define ST_OVR_BIT        5
`define ST_FER_BIT        4
`define ST_PER_BIT        3
`define ST_TEND_BIT       2
`define ST_MPB_BIT        1

// Interrupt status and mask fields
`define IRQ_TXE_BIT       0
`define IRQ_TEND_BIT      1
`define IRQ_RXF_BIT       2
`define IRQ_ERR_BIT       3

// Reset values
`define MODE_RESET        8'h00
`define CONTROL_RESET     8'h00
`define IRQ_MASK_RESET    4'h0

// Last count of the prescale counter per divide ratio
`define PRE_LAST_DIV1     6'h00
`define PRE_LAST_DIV4     6'h03
`define PRE_LAST_DIV16    6'h0F
`define PRE_LAST_DIV64    6'h3F

`endif

// [design/serial_ctrl_pkg.sv]
// Types shared by the serial control block and its prescaler.
// Assumes the offsets and fields come from serial_ctrl_regs.svh.
package serial_ctrl_pkg;

    typedef logic [7:0] byte_t;

    // Prescaler source selection
    typedef enum logic [1:0] {
        PRE_DIV1  = 2'b00,
        PRE_DIV4  = 2'b01,
        PRE_DIV16 = 2'b10,
        PRE_DIV64 = 2'b11
    } prescale_e;

endpackage : serial_ctrl_pkg

// [design/baud_prescaler.sv]
// Prescaler that feeds the baud rate generator from the block clock.
// Assumes the select field is stable while a transfer runs.
`timescale 1ns/1ns
`default_nettype none
`include "serial_ctrl_regs.svh"

module baud_prescaler #(
    parameter int CNT_W = 6
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      run,
    input  wire serial_ctrl_pkg::prescale_e sel,
    output logic                           tick
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] last;

    // Terminal count for the chosen ratio
    always_comb begin
        case (sel)
            serial_ctrl_pkg::PRE_DIV1:  last = `PRE_LAST_DIV1;
            serial_ctrl_pkg::PRE_DIV4:  last = `PRE_LAST_DIV4;
            serial_ctrl_pkg::PRE_DIV16: last = `PRE_LAST_DIV16;
            serial_ctrl_pkg::PRE_DIV64: last = `PRE_LAST_DIV64;
            default:                    last = `PRE_LAST_DIV1;
        endcase
    end

    // Counter restarts whenever the block is idle
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            cnt_reg <= '0;
            tick    <= 1'b0;
        end else if (cnt_reg >= last) begin
            cnt_reg <= '0;
            tick    <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
            tick    <= 1'b0;
        end
    end

endmodule : baud_prescaler
`default_nettype wire

// [tb/serial_ctrl_chk.sv]
// Checker for the serial control block, watching its ports only.
// Assumes offsets and control fields from serial_ctrl_regs.svh.
`timescale 1ns/1ns
`default_nettype none
`include "serial_ctrl_regs.svh"

module serial_ctrl_chk (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       tx_take,
    input  wire logic       baud_tick,
    input  wire logic [1:0] prescale_n,
    input  wire logic       tx_on,
    input  wire logic       rx_on,
    input  wire logic       tx_valid,
    input  wire logic       tx_empty_irq,
    input  wire logic       rx_full_irq,
    input  wire logic       rx_error_irq,
    input  wire logic       tx_done_irq,
    input  wire logic       irq
);
    // Decoded writes and prescaler state seen at the ports
    wire logic wr_ctl  = reg_wr && (reg_addr == `OFS_CONTROL);
    wire logic wr_mode = reg_wr && (reg_addr == `OFS_MODE);
    wire logic wr_mask = reg_wr && (reg_addr == `OFS_IRQ_MASK);
    wire logic run     = tx_on || rx_on;
    wire logic div4    = run && (prescale_n == 2'b01);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_reset_zero;
        disable iff (1'b0) rst |=> !tx_on && !rx_on && !baud_tick && !irq
            && (prescale_n == 2'b00) && !tx_empty_irq && !rx_full_irq
            && !rx_error_irq && !tx_done_irq;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("not reset");
    property p_mode_sel;
        wr_mode |=> prescale_n == $past(reg_wdata[1:0]);
    endproperty
    a_mode_sel: assert property (p_mode_sel) else $error("prescale field");
    property p_div4;
        (baud_tick && div4) ##1 div4 [*4] |-> baud_tick && !$past(baud_tick);
    endproperty
    a_div4: assert property (p_div4) else $error("divide by 4 period");
    property p_idle;
        !run ##1 !run |-> !baud_tick;
    endproperty
    a_idle: assert property (p_idle) else $error("tick while idle");
    property p_enables;
        wr_ctl |=> tx_on == $past(reg_wdata[5]) && rx_on == $past(reg_wdata[4]);
    endproperty
    a_enables: assert property (p_enables) else $error("enable bits");
    property p_tx_gate;
        !tx_on |-> !tx_valid;
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("send while off");
    property p_take;
        tx_take && tx_valid |=> !tx_valid;
    endproperty
    a_take: assert property (p_take) else $error("byte not taken");
    property p_tie_off;
        wr_ctl && !reg_wdata[7] |=> !tx_empty_irq;
    endproperty
    a_tie_off: assert property (p_tie_off) else $error("empty req");
    property p_tie_on;
        wr_ctl && reg_wdata[7] && reg_wdata[5] |=> tx_empty_irq == !tx_valid;
    endproperty
    a_tie_on: assert property (p_tie_on) else $error("empty req");
    property p_rie_off;
        wr_ctl && !reg_wdata[6] |=> !rx_full_irq && !rx_error_irq;
    endproperty
    a_rie_off: assert property (p_rie_off) else $error("rx req");
    property p_tx_done_irq_en_off;
        wr_ctl && !reg_wdata[2] |=> !tx_done_irq;
    endproperty
    a_tx_done_irq_en_off: assert property (p_tx_done_irq_en_off) else $error("end req");
    property p_mask0;
        wr_mask && (reg_wdata[3:0] == 4'h0) |=> !irq;
    endproperty
    a_mask0: assert property (p_mask0) else $error("masked irq");

    // Main scenarios reached
    c_take: cover property (tx_take && tx_valid);
    c_rx_req: cover property ($rose(rx_full_irq));
    c_end_req: cover property ($rose(tx_done_irq));
    c_irq: cover property ($rose(irq));
endmodule : serial_ctrl_chk

bind serial_control_enables serial_ctrl_chk serial_ctrl_chk_i (.*);
`default_nettype wire

// [tb/serial_peer_model.sv]
// Model of the framing side: shifts out offered bytes, hands in frames.
// Assumes the control block's take handshake and one-cycle frame pulses.
`timescale 1ns/1ns
`default_nettype none

module serial_peer_model (
    input  wire logic       clk,
    input  wire logic       slow,
    input  wire logic       tx_valid,
    output logic            tx_take,
    output logic            tx_end_pulse,
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    output logic            rx_mpb,
    output logic            rx_parity_bad,
    output logic            rx_stop_bad
);
    initial begin
        tx_take = 1'b0;
        tx_end_pulse = 1'b0;
        rx_valid = 1'b0;
        rx_byte = 8'hA5;
        rx_mpb = 1'b0;
        rx_parity_bad = 1'b0;
        rx_stop_bad = 1'b0;
    end

    // Take each offered byte after a short or long delay, then end it
    always begin
        @(posedge clk);
        if (tx_valid === 1'b1) begin
            repeat (slow ? 6 : 1) @(posedge clk);
            tx_take <= 1'b1;
            @(posedge clk);
            tx_take <= 1'b0;
            repeat (4) @(posedge clk);
            tx_end_pulse <= 1'b1;
            @(posedge clk);
            tx_end_pulse <= 1'b0;
        end
    end

    // One received frame; lines show no stale value afterwards
    task send_frame(input logic [7:0] b, input logic mpb, input logic par,
                    input logic stp);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_byte <= b;
        rx_mpb <= mpb;
        rx_parity_bad <= par;
        rx_stop_bad <= stp;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_byte <= ~b;
        rx_mpb <= ~mpb;
        rx_parity_bad <= ~par;
        rx_stop_bad <= ~stp;
    endtask : send_frame
endmodule : serial_peer_model
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the serial control block.
// Assumes the peer model on the framing side and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`include "serial_ctrl_regs.svh"

module tb_top;
    logic       clk, rst, reg_wr, reg_rd, slow;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_byte, rx_byte;
    logic       tx_take, tx_end_pulse, rx_valid, rx_mpb, rx_parity_bad;
    logic       rx_stop_bad, baud_tick, tx_on, rx_on, tx_valid;
    logic       tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq, irq;
    logic [1:0] prescale_n;
    int         n_mismatch, tests_run, ticks;
    wire logic [7:0] irqs = {3'h0, tx_empty_irq, rx_full_irq, rx_error_irq,
                             tx_done_irq, irq};

    always #5 clk = ~clk;

    serial_control_enables serial_control_enables_i (.*);

    serial_peer_model serial_peer_model_i (.*);

    // Compare and count
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One-cycle register write
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // One-cycle read; data are taken in the following cycle
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    task wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc

    task count_ticks(input int n);
        ticks = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            ticks += int'(baud_tick);
        end
    endtask : count_ticks

    task results;
        $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        results();
    end

    // Smart card mode is never selected here
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        slow = 1'b1;
        n_mismatch = 0;
        tests_run = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // Reset values and an unmapped read
        rd(`OFS_MODE, 8'h00);
        rd(`OFS_CONTROL, 8'h00);
        rd(`OFS_STATUS, 8'h84);
        rd(`OFS_IRQ_MASK, 8'h00);
        rd(8'h07, 8'h00);
        chk(irqs, 8'h00);
        // Every prescale setting, ticks counted over 128 cycles
        for (int n = 0; n < 4; n++) begin
            wr(`OFS_MODE, 8'(n));
            wr(`OFS_CONTROL, 8'h20);
            wait_cyc(70);
            chk({6'h00, prescale_n}, 8'(n));
            count_ticks(128);
            chk(8'(ticks), 8'(128 >> (2 * n)));
        end
        wr(`OFS_CONTROL, 8'h00);
        wait_cyc(3);
        count_ticks(64);
        chk(8'(ticks), 8'h00);
        wr(`OFS_MODE, 8'h00);
        // Transmit held back while off, then sent with both requests
        wr(`OFS_TX_DATA, 8'h5A);
        wr(`OFS_STATUS, 8'h7F);
        wait_cyc(2);
        chk({7'h00, tx_valid}, 8'h00);
        wr(`OFS_CONTROL, 8'hA4);
        wait_cyc(1);
        chk({7'h00, tx_valid}, 8'h01);
        chk(tx_byte, 8'h5A);
        chk(irqs, 8'h00);
        wait_cyc(20);
        chk(irqs, 8'h12);
        wr(`OFS_CONTROL, 8'h20);
        wait_cyc(1);
        chk(irqs, 8'h00);
        wr(`OFS_STATUS, 8'hFF);
        rd(`OFS_STATUS, 8'h84);
        // Receive off, then on with errors and an overrun
        wr(`OFS_CONTROL, 8'h40);
        serial_peer_model_i.send_frame(8'h3C, 1'b0, 1'b0, 1'b0);
        wait_cyc(1);
        chk(irqs, 8'h00);
        rd(`OFS_STATUS, 8'h84);
        wr(`OFS_CONTROL, 8'h50);
        serial_peer_model_i.send_frame(8'h3C, 1'b0, 1'b0, 1'b0);
        wait_cyc(1);
        chk(irqs, 8'h08);
        rd(`OFS_RX_DATA, 8'h3C);
        wr(`OFS_STATUS, 8'hBF);
        serial_peer_model_i.send_frame(8'h99, 1'b0, 1'b1, 1'b1);
        wait_cyc(1);
        chk(irqs, 8'h0C);
        serial_peer_model_i.send_frame(8'h77, 1'b0, 1'b0, 1'b0);
        rd(`OFS_STATUS, 8'hFC);
        rd(`OFS_RX_DATA, 8'h99);
        wr(`OFS_CONTROL, 8'h10);
        wait_cyc(1);
        chk(irqs, 8'h00);
        wr(`OFS_STATUS, 8'h87);
        rd(`OFS_STATUS, 8'h84);
        // Wake: frames with the bit clear dropped, bit set lands
        wr(`OFS_MODE, 8'h04);
        wr(`OFS_CONTROL, 8'h58);
        serial_peer_model_i.send_frame(8'h11, 1'b0, 1'b0, 1'b1);
        wait_cyc(1);
        chk(irqs, 8'h00);
        rd(`OFS_STATUS, 8'h84);
        rd(`OFS_CONTROL, 8'h58);
        serial_peer_model_i.send_frame(8'h22, 1'b1, 1'b0, 1'b0);
        rd(`OFS_CONTROL, 8'h50);
        rd(`OFS_STATUS, 8'hC6);
        rd(`OFS_RX_DATA, 8'h22);
        // Wake has no effect in clocked synchronous mode
        wr(`OFS_STATUS, 8'h87);
        wr(`OFS_MODE, 8'h84);
        wr(`OFS_CONTROL, 8'h58);
        serial_peer_model_i.send_frame(8'h33, 1'b0, 1'b0, 1'b0);
        rd(`OFS_STATUS, 8'hC4);
        rd(`OFS_CONTROL, 8'h58);
        // Sticky interrupt status, mask and write-one clear
        wr(`OFS_STATUS, 8'h87);
        wr(`OFS_IRQ_STATUS, 8'h0F);
        serial_peer_model_i.send_frame(8'h44, 1'b1, 1'b0, 1'b0);
        wait_cyc(2);
        chk(irqs, 8'h08);
        rd(`OFS_IRQ_STATUS, 8'h04);
        wr(`OFS_IRQ_MASK, 8'h04);
        wait_cyc(1);
        chk(irqs, 8'h09);
        wr(`OFS_IRQ_STATUS, 8'h04);
        wait_cyc(1);
        chk(irqs, 8'h08);
        rd(`OFS_IRQ_MASK, 8'h04);
        wr(`OFS_IRQ_MASK, 8'h00);
        wait_cyc(2);
        results();
    end
endmodule : tb_top
`default_nettype wire
